// >>> rtl/uart_rx_control.sv
// UART receive control: baud counter, readback, address filter,
// infrared codec, event interrupts, APB register slave.
// Assumes: receiver, transmitter and bus all run on pclk.
//
// Notes on behaviour
// - Rx off, select 0: reload value read
// - Rx off, select 1: count zero interrupts
// - Rx off, select 1: live count read
// - Rx on: select picks count or reload
// - Suppress 0: data and errors interrupt
// - Suppress 1: errors interrupt, data does not
// - Infrared off: serial data passes plainly
// - Infrared on: serial data through codec
// - Eight-bit node address, reset zero
// - Multinode bit one compares address bytes
// - Multinode bit one: data flagged only after address match
// - High and low bytes form divisor
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module uart_rx_control
(
	input  wire logic        pclk,          // System clock, 100 MHz
	input  wire logic        presetn,       // Async reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB access phase
	input  wire logic        pwrite,        // APB direction
	input  wire logic [15:0] paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error, unmapped
	input  wire logic        rx_byte_valid, // Receiver byte strobe
	input  wire logic [7:0]  rx_byte,       // Received byte
	input  wire logic        rx_is_address, // Byte is an address
	input  wire logic        rx_error,      // Receiver error strobe
	input  wire logic        rx_data_taken, // Data consumed strobe
	input  wire logic        tx_serial,     // Transmitter bit stream
	input  wire logic        rxd_pin,       // Serial/infrared pin
	output logic             txd_pin,       // Serial/infrared drive
	output logic             rx_serial,     // Decoded line to receiver
	output logic             rx_enable,     // Receiver enable bit
	output logic      [1:0]  multinode_mode, // Multinode mode field
	output logic             rx_data_available, // Accepted byte held
	output logic             baud_tick,     // Counter reached zero
	output logic             irq            // Level interrupt
);

	// ************************************************
	// State
	// ************************************************
	typedef struct packed {
		logic [7:0]  node_address_compare; // Node address
		logic [7:0]  baud_divisor_high;    // Divisor high byte
		logic [7:0]  baud_divisor_low;     // Divisor low byte
		logic [15:0] baud_divider_counter; // Live count
		logic        rx_enable;            // Receiver enable
		logic [1:0]  multinode_mode;       // Multinode field
		logic        baud_readback_select; // Count or reload readback
		logic        rx_data_irq_suppress; // Drop data interrupts
		logic        infrared_codec_enable; // Codec path select
		logic [uart_ctl_pkg::EV_COUNT-1:0] status; // Sticky events
		logic [uart_ctl_pkg::EV_COUNT-1:0] mask;   // Event mask
		logic        irq;                  // Interrupt out
		logic        rx_data_available;    // Data available
		logic        addr_matched;         // Last address matched
		logic        tick;                 // Baud tick out
		logic [31:0] prdata;               // Read data
		logic        pready;               // Ready
		logic        pslverr;              // Error
		logic [1:0]  rx_sync;              // Pin synchroniser
		logic        tx_prev;              // Last tx bit
		logic [3:0]  tx_phase;             // Ticks into tx bit
		logic        txd;                  // Pin drive
		logic [3:0]  ir_hold;              // Rx pulse stretch
		logic        rxd;                  // Line to receiver
	} state_s;

	state_s st;      // Registered state
	state_s next_st; // Next state

	// Map a byte address onto a register
	function automatic uart_ctl_pkg::reg_e reg_sel(input logic [15:0] a);
		logic [15:0] idx;
		idx = a / 16'(uart_ctl_pkg::ADDR_SCALE);
		if (a[1:0] != 2'h0)
			reg_sel = uart_ctl_pkg::R_NONE;
		else if (idx == uart_ctl_pkg::CTL0_IDX)
			reg_sel = uart_ctl_pkg::R_CTL0;
		else if (idx == uart_ctl_pkg::CTL1_IDX)
			reg_sel = uart_ctl_pkg::R_CTL1;
		else if (idx == uart_ctl_pkg::NODE_IDX)
			reg_sel = uart_ctl_pkg::R_NODE;
		else if (idx == uart_ctl_pkg::DIV_HI_IDX)
			reg_sel = uart_ctl_pkg::R_DIV_HI;
		else if (idx == uart_ctl_pkg::DIV_LO_IDX)
			reg_sel = uart_ctl_pkg::R_DIV_LO;
		else if (idx == uart_ctl_pkg::STATUS_IDX)
			reg_sel = uart_ctl_pkg::R_STATUS;
		else if (idx == uart_ctl_pkg::MASK_IDX)
			reg_sel = uart_ctl_pkg::R_MASK;
		else
			reg_sel = uart_ctl_pkg::R_NONE;
	endfunction : reg_sel

	// Bus decode and events
	logic                              wr_go;     // Write completes
	logic                              accept;    // Byte passes filter
	logic                              baud_evt;  // Idle count zero
	logic [uart_ctl_pkg::EV_COUNT-1:0] ev_set;    // Event set bits
	logic [15:0]                       divisor;   // Reload value
	logic [15:0]                       readback;  // Readback source
	logic                              raw_rx;    // Synchronised pin

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb
	begin
		next_st  = st;
		divisor  = {st.baud_divisor_high, st.baud_divisor_low};
		wr_go    = psel & penable & st.pready & pwrite;
		raw_rx   = st.rx_sync[1];
		accept   = 1'b0;
		baud_evt = 1'b0;
		ev_set   = '0;

		// Pin synchroniser, first stage read by second only
		next_st.rx_sync = {st.rx_sync[0], rxd_pin};

		// Baud counter counts down and reloads at zero
		next_st.tick = (st.baud_divider_counter == 16'h0000);
		if (st.baud_divider_counter == 16'h0000)
			next_st.baud_divider_counter = divisor;
		else
			next_st.baud_divider_counter = st.baud_divider_counter - 16'h0001;

		// Idle receiver with readback select 1 raises interrupts on count zero
		baud_evt = next_st.tick & ~st.rx_enable
			& st.baud_readback_select;

		// Address filter and data acceptance
		if (rx_byte_valid)
		begin
			if (st.multinode_mode[1] && rx_is_address)
			begin
				// Compare each address byte with node address
				accept = (rx_byte == st.node_address_compare);
				next_st.addr_matched = accept;
			end
			else
				accept = ~st.multinode_mode[1] | st.addr_matched;
		end

		// Event bits, data ones only when not suppressed
		ev_set[uart_ctl_pkg::EV_DATA]  = accept
			& ~st.rx_data_irq_suppress;
		ev_set[uart_ctl_pkg::EV_ERROR] = rx_error;
		ev_set[uart_ctl_pkg::EV_BAUD]  = baud_evt;

		// Data available, set wins over clear
		if (rx_data_taken)
			next_st.rx_data_available = 1'b0;
		if (accept)
			next_st.rx_data_available = 1'b1;

		// Register writes take effect at the ready edge
		if (wr_go)
		begin
			case (reg_sel(paddr))
				uart_ctl_pkg::R_CTL0:
				begin
					next_st.rx_enable = pwdata[uart_ctl_pkg::RX_ENABLE_BIT];
					next_st.multinode_mode =
						pwdata[uart_ctl_pkg::MULTINODE_LSB +: 2];
				end
				uart_ctl_pkg::R_CTL1:
				begin
					next_st.baud_readback_select =
						pwdata[uart_ctl_pkg::READBACK_BIT];
					next_st.rx_data_irq_suppress =
						pwdata[uart_ctl_pkg::DATA_SUPPRESS_BIT];
					next_st.infrared_codec_enable =
						pwdata[uart_ctl_pkg::INFRARED_BIT];
				end
				uart_ctl_pkg::R_NODE:
					next_st.node_address_compare = pwdata[7:0];
				uart_ctl_pkg::R_DIV_HI:
					next_st.baud_divisor_high = pwdata[7:0];
				uart_ctl_pkg::R_DIV_LO:
					next_st.baud_divisor_low = pwdata[7:0];
				uart_ctl_pkg::R_STATUS:
					next_st.status = st.status
						& ~pwdata[uart_ctl_pkg::EV_COUNT-1:0];
				uart_ctl_pkg::R_MASK:
					next_st.mask = pwdata[uart_ctl_pkg::EV_COUNT-1:0];
				default:
					next_st.pslverr = st.pslverr;
			endcase
		end
		// Events set after the clear, so set wins
		next_st.status = next_st.status | ev_set;
		next_st.irq    = |(next_st.status & next_st.mask);

		// Readback picks live count or reload value
		if (st.baud_readback_select)
			readback = st.baud_divider_counter;
		else
			readback = divisor;

		// Setup phase captures read data, access phase answers
		next_st.pready = psel & ~penable;
		if (psel && !penable)
		begin
			next_st.pslverr = (reg_sel(paddr) == uart_ctl_pkg::R_NONE);
			case (reg_sel(paddr))
				uart_ctl_pkg::R_CTL0:
					next_st.prdata = {29'h0, st.multinode_mode,
						st.rx_enable};
				uart_ctl_pkg::R_CTL1:
					next_st.prdata = {29'h0, st.baud_readback_select,
						st.rx_data_irq_suppress, st.infrared_codec_enable};
				uart_ctl_pkg::R_NODE:
					next_st.prdata = {24'h0, st.node_address_compare};
				uart_ctl_pkg::R_DIV_HI:
					next_st.prdata = {24'h0, readback[15:8]};
				uart_ctl_pkg::R_DIV_LO:
					next_st.prdata = {24'h0, readback[7:0]};
				uart_ctl_pkg::R_STATUS:
					next_st.prdata = {29'h0, st.status};
				uart_ctl_pkg::R_MASK:
					next_st.prdata = {29'h0, st.mask};
				default:
					next_st.prdata = 32'h0;
			endcase
		end

		// Transmit: bit phase restarts on each tx edge
		next_st.tx_prev = tx_serial;
		if (tx_serial != st.tx_prev)
			next_st.tx_phase = 4'h0;
		else if (next_st.tick && st.tx_phase != 4'hf)
			next_st.tx_phase = st.tx_phase + 4'h1;
		if (st.infrared_codec_enable)
			next_st.txd = ~tx_serial
				& (next_st.tx_phase < uart_ctl_pkg::IR_PULSE_TICKS);
		else
			next_st.txd = tx_serial;

		// Receive: pulse stretched to a low bit when codec on
		if (raw_rx)
			next_st.ir_hold = uart_ctl_pkg::IR_HOLD_TICKS;
		else if (next_st.tick && st.ir_hold != 4'h0)
			next_st.ir_hold = st.ir_hold - 4'h1;
		if (st.infrared_codec_enable)
			next_st.rxd = ~(raw_rx | (st.ir_hold != 4'h0));
		else
			next_st.rxd = raw_rx;
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.node_address_compare <= uart_ctl_pkg::NODE_RESET;
			st.baud_divisor_high    <= uart_ctl_pkg::DIV_RESET;
			st.baud_divisor_low     <= uart_ctl_pkg::DIV_RESET;
			st.baud_divider_counter <= {uart_ctl_pkg::DIV_RESET,
				uart_ctl_pkg::DIV_RESET};
			st.rx_sync              <= 2'h3;
			st.tx_prev              <= 1'b1;
			st.txd                  <= 1'b1;
			st.rxd                  <= 1'b1;
		end
		else
			st <= next_st;
	end

	// Outputs straight from state
	assign prdata            = st.prdata;
	assign pready            = st.pready;
	assign pslverr           = st.pslverr;
	assign txd_pin           = st.txd;
	assign rx_serial         = st.rxd;
	assign rx_enable         = st.rx_enable;
	assign multinode_mode    = st.multinode_mode;
	assign rx_data_available = st.rx_data_available;
	assign baud_tick         = st.tick;
	assign irq               = st.irq;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Read setup of a register
	sequence s_rd_setup(uart_ctl_pkg::reg_e r);
		psel && !penable && !pwrite && reg_sel(paddr) == r;
	endsequence
	// Completed write to a register
	sequence s_wr_done(uart_ctl_pkg::reg_e r);
		psel && penable && pready && pwrite && reg_sel(paddr) == r;
	endsequence

	a_read_reload: assert property (
		s_rd_setup(uart_ctl_pkg::R_DIV_HI) ##0 !st.baud_readback_select
		|=> prdata[7:0] == $past(st.baud_divisor_high) && pready)
		else $error("Reload value not returned");
	a_read_count: assert property (
		s_rd_setup(uart_ctl_pkg::R_DIV_LO) ##0 st.baud_readback_select
		|=> prdata[7:0] == $past(st.baud_divider_counter[7:0]))
		else $error("Live count not returned");
	a_idle_baud_irq: assert property (
		st.baud_divider_counter == 16'h0000 && !rx_enable
		&& st.baud_readback_select
		|=> st.status[uart_ctl_pkg::EV_BAUD])
		else $error("Idle count zero raised no event");
	a_data_irq: assert property (
		rx_byte_valid && !multinode_mode[1] && !st.rx_data_irq_suppress
		|=> st.status[uart_ctl_pkg::EV_DATA] && rx_data_available)
		else $error("Received byte raised no event");
	a_data_suppressed: assert property (
		st.rx_data_irq_suppress && !st.status[uart_ctl_pkg::EV_DATA]
		|=> !st.status[uart_ctl_pkg::EV_DATA])
		else $error("Suppressed data raised event");
	a_error_irq: assert property (
		rx_error && st.mask[uart_ctl_pkg::EV_ERROR] |=> irq)
		else $error("Error raised no interrupt");
	a_plain_path: assert property (
		!st.infrared_codec_enable |=> txd_pin == $past(tx_serial))
		else $error("Plain transmit path broken");
	a_codec_idle: assert property (
		(st.infrared_codec_enable && tx_serial) [*2] |=> !txd_pin)
		else $error("Codec drove pulse on a one bit");
	a_node_write: assert property (
		s_wr_done(uart_ctl_pkg::R_NODE)
		|=> st.node_address_compare == $past(pwdata[7:0]))
		else $error("Node address not stored");
	a_addr_mismatch: assert property (
		rx_byte_valid && rx_is_address && multinode_mode[1]
		&& rx_byte != st.node_address_compare && !rx_data_available
		|=> !st.addr_matched && !rx_data_available)
		else $error("Mismatched address accepted");
	a_reload: assert property (
		st.baud_divider_counter == 16'h0000 && !wr_go
		|=> st.baud_divider_counter == $past(divisor) && baud_tick)
		else $error("Counter did not reload");

endmodule : uart_rx_control

`default_nettype wire

// >>> rtl/uart_ctl_pkg.sv
// Package: register indices, field positions, resets, timing counts
// Assumes: APB byte address is four times a register index
package uart_ctl_pkg;

	// ************************************************
	// Register indices and byte addresses
	// ************************************************
	localparam logic [15:0] CTL0_IDX     = 16'h0f42; // Enable, multinode
	localparam logic [15:0] CTL1_IDX     = 16'h0f43; // Readback, irq, infrared
	localparam logic [15:0] NODE_IDX     = 16'h0f45; // Node address compare
	localparam logic [15:0] DIV_HI_IDX   = 16'h0f46; // Baud divisor high
	localparam logic [15:0] DIV_LO_IDX   = 16'h0f47; // Baud divisor low
	localparam logic [15:0] STATUS_IDX   = 16'h0f48; // Sticky events
	localparam logic [15:0] MASK_IDX     = 16'h0f49; // Interrupt mask
	localparam int          ADDR_SCALE   = 4;        // Bytes per word

	// ************************************************
	// Field positions
	// ************************************************
	localparam int RX_ENABLE_BIT    = 0; // Control 0
	localparam int MULTINODE_LSB    = 1; // Control 0, two bits
	localparam int READBACK_BIT     = 2; // Control 1
	localparam int DATA_SUPPRESS_BIT = 1; // Control 1
	localparam int INFRARED_BIT     = 0; // Control 1
	localparam int EV_DATA          = 0; // Status: byte received
	localparam int EV_ERROR         = 1; // Status: receiver error
	localparam int EV_BAUD          = 2; // Status: idle baud count zero
	localparam int EV_COUNT         = 3; // Number of event bits

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [7:0] NODE_RESET   = 8'h00;
	localparam logic [7:0] DIV_RESET    = 8'hff;
	localparam logic [7:0] CTL_RESET    = 8'h00;

	// ************************************************
	// Infrared timing in baud ticks
	// ************************************************
	localparam logic [3:0] IR_PULSE_TICKS = 4'h3; // Pulse per zero bit
	localparam logic [3:0] IR_HOLD_TICKS  = 4'hf; // Stretch of rx pulse

	// Register selection
	typedef enum logic [2:0] {
		R_NONE, R_CTL0, R_CTL1, R_NODE, R_DIV_HI, R_DIV_LO, R_STATUS, R_MASK
	} reg_e;

endpackage : uart_ctl_pkg

// >>> bench/far_node.sv
// Far-side node: plain serial or infrared transceiver on the pins
// Assumes: runs on the block clock; the bench picks the signalling
`timescale 1ns/1ns
`default_nettype none

module far_node
(
	input  wire logic pclk,     // Shared clock
	input  wire logic ir,       // Infrared signalling chosen
	input  wire logic txd_pin,  // Line from the block
	output logic      rxd_pin,  // Line into the block
	output int        tx_edges  // Rising edges seen on txd_pin
);
	logic last_tx; // Previous line level

	// ************************************************
	// Line watch
	// ************************************************
	// Idle mark level until told otherwise
	initial
	begin
		rxd_pin = 1'b1;
	end

	// Count light pulses or rising marks from the block
	always @(posedge pclk)
	begin
		if (txd_pin && !last_tx)
			tx_edges <= tx_edges + 1;
		last_tx <= txd_pin;
	end

	// Set the line level at a clock edge
	task drive(input logic b);
		rxd_pin <= b;
	endtask : drive

	// Zero bit: light pulse on infrared, low level on plain; then idle
	task send(input int n);
		@(posedge pclk);
		rxd_pin <= ir;
		repeat (n) @(posedge pclk);
		rxd_pin <= !ir;
	endtask : send
endmodule : far_node
`default_nettype wire

// >>> bench/tb_uart_rx_control.sv
// Bench for the receive control block: APB, strobes, pins
// Assumes: far_node drives the receive pin; one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none

module tb_uart_rx_control;
	localparam logic [15:0] CTL0 = uart_ctl_pkg::CTL0_IDX;
	localparam logic [15:0] CTL1 = uart_ctl_pkg::CTL1_IDX;
	localparam logic [15:0] NODE = uart_ctl_pkg::NODE_IDX;
	localparam logic [15:0] DHI  = uart_ctl_pkg::DIV_HI_IDX;
	localparam logic [15:0] DLO  = uart_ctl_pkg::DIV_LO_IDX;
	localparam logic [15:0] STAT = uart_ctl_pkg::STATUS_IDX;
	localparam logic [15:0] MSK  = uart_ctl_pkg::MASK_IDX;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  rx_byte;
	logic        rx_byte_valid, rx_is_address, rx_error, rx_data_taken;
	logic        tx_serial, rxd_pin, txd_pin, rx_serial, rx_enable;
	logic        rx_data_available, baud_tick, irq, ir, err;
	logic [1:0]  multinode_mode;
	int          miscompares, compares, seed, i, r1, n;
	int          mdl [int];     // Register model by index
	logic [15:0] ix [7];        // Register indices
	int          rv [7];        // Reset values
	logic        qt [$];        // Transmit bits driven
	logic        qr [$];        // Pin bits driven

	uart_rx_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .rx_is_address(rx_is_address),
		.rx_error(rx_error), .rx_data_taken(rx_data_taken),
		.tx_serial(tx_serial), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
		.rx_serial(rx_serial), .rx_enable(rx_enable),
		.multinode_mode(multinode_mode),
		.rx_data_available(rx_data_available),
		.baud_tick(baud_tick), .irq(irq));
	far_node far (.pclk(pclk), .ir(ir), .txd_pin(txd_pin),
		.rxd_pin(rxd_pin), .tx_edges());

	// Free-running clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready under a bound
	task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= 16'(idx * uart_ctl_pkg::ADDR_SCALE);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50)
			miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w)
			mdl[idx] = d & 32'h0000_00ff;
	endtask : apb

	// Read and compare against the model
	task rchk(input logic [15:0] idx);
		apb(1'b0, idx, 32'h0);
		chk(rd, mdl[idx]);
	endtask : rchk

	// Receiver strobes: {taken, error, address, valid}
	task strobe(input logic [3:0] k, input logic [7:0] b);
		@(posedge pclk);
		rx_byte_valid <= k[0];
		rx_is_address <= k[1];
		rx_error <= k[2];
		rx_data_taken <= k[3];
		rx_byte <= b;
		@(posedge pclk);
		rx_byte_valid <= 1'b0;
		rx_error <= 1'b0;
		rx_data_taken <= 1'b0;
		@(posedge pclk);
		#1;
	endtask : strobe

	// Count baud ticks over a window
	task tcount(input int w);
		n = 0;
		repeat (w)
		begin
			@(posedge pclk);
			#1;
			if (baud_tick === 1'b1)
				n++;
		end
	endtask : tcount

	// Wait for the next baud tick under a bound
	task wtick(input int lim);
		n = 0;
		do
		begin
			@(posedge pclk);
			#1;
		end
		while (baud_tick !== 1'b1 && ++n < lim);
		if (n >= lim)
			miscompares++;
	endtask : wtick

	// Verdict and end of run
	task summarize;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Hang guard
	initial
	begin
		// First reload waits for the full reset count to drain
		#950000;
		miscompares++;
		summarize();
	end

	// ************************************************
	// Main sequence
	// ************************************************
	initial
	begin
		seed = 32'hf1c7;
		{psel, penable, pwrite, rx_byte_valid, rx_is_address} = '0;
		{rx_error, rx_data_taken, ir, paddr, pwdata, rx_byte} = '0;
		tx_serial = 1'b1;
		presetn = 1'b0;
		ix = '{CTL0, CTL1, NODE, DHI, DLO, STAT, MSK};
		rv = '{0, 0, 0, 255, 255, 0, 0};
		repeat (12) @(posedge pclk);
		chk({txd_pin, rx_serial}, 2'b11);
		presetn <= 1'b1;
		foreach (ix[j])
			mdl[ix[j]] = rv[j];
		foreach (ix[j])
			rchk(ix[j]);
		apb(1'b0, 16'h0f44, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, NODE, $random(seed));
		rchk(NODE);
		// Combined divisor sets the tick period
		apb(1'b1, DHI, 32'h1);
		apb(1'b1, DLO, 32'h0);
		wtick(70000);
		tcount(514);
		chk(n, 2);
		apb(1'b1, DHI, 32'h0);
		apb(1'b1, DLO, 32'h9);
		rchk(DHI);
		wtick(300);
		// Live count or reload, receiver off then on
		for (i = 0; i < 2; i++)
		begin
			apb(1'b1, CTL0, i);
			apb(1'b1, CTL1, 32'h4);
			apb(1'b0, DLO, 32'h0);
			r1 = rd;
			apb(1'b0, DLO, 32'h0);
			chk(rd, (r1 + 7) % 10);
			apb(1'b1, CTL1, 32'h0);
			rchk(DLO);
		end
		// Idle counter interrupts with receiver off
		apb(1'b1, CTL0, 32'h0);
		apb(1'b1, MSK, 32'h4);
		apb(1'b1, CTL1, 32'h4);
		tcount(100);
		chk(n, 32'd10);
		chk(irq, 1'b1);
		apb(1'b1, CTL1, 32'h0);
		apb(1'b1, STAT, 32'h7);
		tcount(30);
		apb(1'b0, STAT, 32'h0);
		chk(rd, 32'h0);
		chk(irq, 1'b0);
		// Data interrupts with suppress off and on
		apb(1'b1, MSK, 32'h3);
		apb(1'b1, CTL0, 32'h1);
		for (i = 0; i < 2; i++)
		begin
			apb(1'b1, CTL1, i * 2);
			strobe(4'h1, 8'h5a);
			chk(irq, i == 0);
			apb(1'b1, STAT, 32'h7);
			strobe(4'h4, 8'h0);
			chk(irq, 1'b1);
			apb(1'b1, STAT, 32'h7);
		end
		apb(1'b1, MSK, 32'h0);
		strobe(4'h4, 8'h0);
		apb(1'b0, STAT, 32'h0);
		chk({rd[1], irq}, 2'b10);
		apb(1'b1, STAT, 32'h2);
		apb(1'b0, STAT, 32'h0);
		chk(rd, 32'h0);
		// Address filter in multinode mode
		strobe(4'h8, 8'h0);
		apb(1'b1, CTL0, 32'h5);
		strobe(4'h1, 8'h11);
		chk(rx_data_available, 1'b0);
		strobe(4'h3, 8'(mdl[NODE]) ^ 8'h01);
		chk(rx_data_available, 1'b0);
		strobe(4'h3, 8'(mdl[NODE]));
		chk(rx_data_available, 1'b1);
		strobe(4'h8, 8'h0);
		strobe(4'h1, 8'h22);
		chk(rx_data_available, 1'b1);
		// Plain pins follow with fixed delays
		for (i = 0; i < 40; i++)
		begin
			@(posedge pclk);
			qt.push_back(1'($random(seed)));
			qr.push_back(1'($random(seed)));
			tx_serial <= qt[$];
			far.drive(qr[$]);
			#1;
			if (i > 4)
				chk({txd_pin, rx_serial}, {qt[$-1], qr[$-3]});
		end
		// Infrared codec in both directions
		apb(1'b1, CTL1, 32'h1);
		ir = 1'b1;
		far.drive(1'b0);
		tx_serial <= 1'b1;
		repeat (300) @(posedge pclk);
		chk({txd_pin, rx_serial}, 2'b01);
		r1 = far.tx_edges;
		tx_serial <= 1'b0;
		repeat (2000) @(posedge pclk);
		chk(far.tx_edges > r1, 1'b1);
		far.send(2);
		repeat (3) @(posedge pclk);
		#1;
		chk(rx_serial, 1'b0);
		summarize();
	end
endmodule : tb_uart_rx_control
`default_nettype wire
